// file: src/lvm_consts.svh
// Notes on behaviour
// - Twelve reaction codes choose ON, OFF or silence for each crossing direction.
// - Exceed-first: change above threshold, reverse only below threshold minus hysteresis.
// - Undershoot-first: change below threshold, reverse only above threshold plus hysteresis.
// - A crossing whose reaction is silent sends nothing; the other direction still acts.
// - Sixteen-bit external source takes threshold from a written two-byte value object.
// - Eight-bit external source takes threshold from a written one-byte value object.
// - Teach source latches present measured value as threshold on each store object.
// - Configuration download drops external threshold until a fresh value arrives.
// - Output goes to 1 only after the selected switch-on delay elapses.
// - During switch-on delay, cyclic telegrams still carry 0.
// - Output goes to 0 only after the selected switch-off delay elapses.
// - During switch-off delay, cyclic telegrams still carry 1.
// - Silent reaction for the fulfilled condition also suppresses cyclic telegrams.
// - Send-on-change transmits the output on every 0-to-1 and 1-to-0 transition.
// - Without send-on-change, no transition telegram, but cyclic sending continues.
// - Cyclic period is setting times ten seconds, setting up to 120, zero disables.
// - No send-on-change and cycle zero means the output is never transmitted.
// - Threshold is limited to minus fifteen through plus fifty degrees Celsius.
// - Hysteresis selectable as none, 1, 2, 3, 4, 5, 10, 15 or 20 kelvin.
`ifndef LVM_CONSTS_SVH
`define LVM_CONSTS_SVH

// Register byte offsets on the Wishbone slave.
`define LVM_A_CTRL      8'h00
`define LVM_A_THRESH    8'h04
`define LVM_A_CYCLE     8'h08
`define LVM_A_EXT16     8'h0C
`define LVM_A_EXT8      8'h10
`define LVM_A_TEACH     8'h14
`define LVM_A_STATUS    8'h18
`define LVM_A_MEAS      8'h1C

// Writable control bits and reset values.
`define LVM_CTRL_WMASK  32'h000F_FF7F
`define LVM_CTRL_RST    32'h0000_0040
`define LVM_THR_RST     16'h00C8
`define LVM_CYCLE_RST   7'h00

// Status field positions.
`define LVM_ST_OUT      0
`define LVM_ST_TARGET   1
`define LVM_ST_COND     2
`define LVM_ST_PEND     3
`define LVM_ST_EXTV     4
`define LVM_ST_SILENT   5
`define LVM_ST_THR_LSB  16

// Threshold limits in tenths of a degree.
`define LVM_THR_MIN     16'hFF6A
`define LVM_THR_MAX     16'h01F4

// Timing: clock period, tick period and cycle unit.
`define LVM_CLK_PERIOD_PS 4000
`define LVM_TICK_S        1
`define LVM_TICK_CYCLES   ((`LVM_TICK_S * 64'd1000000000000) / `LVM_CLK_PERIOD_PS)
`define LVM_CYCLE_UNIT_S  11'h00A
`define LVM_CYCLE_MAX     7'h78

`endif

// file: src/lvm_pkg.sv
`default_nettype none
package lvm_pkg;

  typedef enum logic [1:0] {LVM_ACT_NONE, LVM_ACT_ON, LVM_ACT_OFF} lvm_act_t;

  typedef enum logic [1:0] {LVM_SRC_FIXED, LVM_SRC_EXT16, LVM_SRC_EXT8, LVM_SRC_TEACH} lvm_src_t;

  typedef struct packed {
    logic     ex_first;
    lvm_act_t act_exc;
    lvm_act_t act_und;
  } lvm_react_t;

  typedef struct packed {
    logic [11:0] rsvd;
    logic [3:0]  off_dly;
    logic [3:0]  on_dly;
    logic [3:0]  hyst;
    logic        rsvd1;
    logic        soc;
    lvm_src_t    src;
    logic [3:0]  reaction;
  } lvm_ctrl_t;

  typedef struct packed {
    logic valid;
    logic value;
  } lvm_tx_t;

  typedef struct packed {
    lvm_ctrl_t   ctrl;
    logic [15:0] cfg_thr;
    logic [6:0]  cycle;
    logic [15:0] ext_thr;
    logic        ext_valid;
    logic        cond;
    logic        target;
    logic        out;
    logic        silent;
    logic [11:0] dly_cnt;
    logic [10:0] cyc_cnt;
    logic        ack;
    logic [31:0] rdata;
    lvm_tx_t     tx;
  } lvm_state_t;

  typedef struct packed {
    logic [27:0] cnt;
    logic        tick;
  } lvm_tick_st_t;

endpackage
`default_nettype wire

// file: src/lvm_tick.sv
`timescale 1ns/10ps
`default_nettype none
module lvm_tick #(
  parameter int unsigned TICK_CYCLES = 250000000
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset_n,
  // One-cycle enable pulse per tick period.
  output logic      tick
);

  if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h0FFF_FFFF) begin : g_bad_tick
    $error("lvm_tick: TICK_CYCLES out of range");
  end

  localparam logic [27:0] LAST = 28'(TICK_CYCLES - 1);

  lvm_pkg::lvm_tick_st_t st_r;
  lvm_pkg::lvm_tick_st_t st_nxt;

  // Free-running divider; the pulse lasts one clock at the wrap.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cnt == LAST) begin
      st_nxt.cnt = 28'h000_0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = 28'(st_r.cnt + 28'h000_0001);
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule
`default_nettype wire

// file: src/lvm_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "lvm_consts.svh"
module lvm_core #(
  parameter int unsigned TICK_CYCLES = 32'(`LVM_TICK_CYCLES)
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Measured value, signed tenths of a degree, same clock domain.
  input  wire logic [15:0] meas_value,
  // Outgoing limit telegram and present object state.
  output logic             tx_valid,
  output logic             tx_value,
  output logic             limit_out
);

  // Short aliases keep the reaction table readable.
  localparam lvm_pkg::lvm_act_t A_NO  = lvm_pkg::LVM_ACT_NONE;
  localparam lvm_pkg::lvm_act_t A_ON  = lvm_pkg::LVM_ACT_ON;
  localparam lvm_pkg::lvm_act_t A_OFF = lvm_pkg::LVM_ACT_OFF;

  // Reset image of the whole state; every field not named here starts at zero.
  localparam lvm_pkg::lvm_state_t ST_RST = '{
    ctrl:    `LVM_CTRL_RST,
    cfg_thr: `LVM_THR_RST,
    cycle:   `LVM_CYCLE_RST,
    default: '0
  };

  lvm_pkg::lvm_state_t st_r;
  lvm_pkg::lvm_state_t st_nxt;
  logic                tick_1s;

  // Reaction table: which way is the first crossing and what each direction does.
  function automatic lvm_pkg::lvm_react_t react_decode(input logic [3:0] code);
    lvm_pkg::lvm_react_t r;
    r = '{1'b1, A_ON, A_OFF};
    case (code)
      4'h0: r = '{1'b1, A_ON,  A_OFF};
      4'h1: r = '{1'b1, A_OFF, A_ON};
      4'h2: r = '{1'b0, A_OFF, A_ON};
      4'h3: r = '{1'b0, A_ON,  A_OFF};
      4'h4: r = '{1'b1, A_ON,  A_NO};
      4'h5: r = '{1'b1, A_OFF, A_NO};
      4'h6: r = '{1'b0, A_NO,  A_ON};
      4'h7: r = '{1'b0, A_NO,  A_OFF};
      4'h8: r = '{1'b1, A_NO,  A_OFF};
      4'h9: r = '{1'b1, A_NO,  A_ON};
      4'hA: r = '{1'b0, A_OFF, A_NO};
      4'hB: r = '{1'b0, A_ON,  A_NO};
      default: r = '{1'b1, A_ON, A_OFF};
    endcase
    return r;
  endfunction

  // Delay choice in whole seconds; unused codes behave as no delay.
  function automatic logic [11:0] delay_secs(input logic [3:0] sel);
    logic [11:0] s;
    s = 12'h000;
    case (sel)
      4'h1: s = 12'h001;
      4'h2: s = 12'h003;
      4'h3: s = 12'h005;
      4'h4: s = 12'h00A;
      4'h5: s = 12'h00F;
      4'h6: s = 12'h01E;
      4'h7: s = 12'h03C;
      4'h8: s = 12'h0B4;
      4'h9: s = 12'h12C;
      4'hA: s = 12'h258;
      4'hB: s = 12'h384;
      4'hC: s = 12'h708;
      4'hD: s = 12'hE10;
      default: s = 12'h000;
    endcase
    return s;
  endfunction

  // Hysteresis in tenths of a kelvin; unused codes mean no hysteresis.
  function automatic logic signed [16:0] hyst_tenths(input logic [3:0] sel);
    logic signed [16:0] h;
    h = 17'sh0_0000;
    case (sel)
      4'h1: h = 17'sh0_000A;
      4'h2: h = 17'sh0_0014;
      4'h3: h = 17'sh0_001E;
      4'h4: h = 17'sh0_0028;
      4'h5: h = 17'sh0_0032;
      4'h6: h = 17'sh0_0064;
      4'h7: h = 17'sh0_0096;
      4'h8: h = 17'sh0_00C8;
      default: h = 17'sh0_0000;
    endcase
    return h;
  endfunction

  // Keeps any threshold, fixed or received, inside the legal span.
  function automatic logic [15:0] clamp_thr(input logic [15:0] t);
    logic [15:0] c;
    c = t;
    if ($signed(t) < $signed(`LVM_THR_MIN)) begin
      c = `LVM_THR_MIN;
    end else if ($signed(t) > $signed(`LVM_THR_MAX)) begin
      c = `LVM_THR_MAX;
    end
    return c;
  endfunction

  // Byte-lane merge of a Wishbone write into an old word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // One-second enable that paces every timer.
  lvm_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick    (tick_1s)
  );

  // Next-state logic for bus, comparator, delay and cyclic sending.
  always_comb begin
    lvm_pkg::lvm_react_t react;
    logic [15:0]         thr;
    logic signed [16:0]  hyst;
    logic signed [16:0]  upper;
    logic signed [16:0]  lower;
    logic signed [16:0]  meas;
    logic                req;
    logic                crossed;
    lvm_pkg::lvm_act_t   act;
    logic [11:0]         dsec;
    logic                commit;
    logic                cyc_fire;
    logic [31:0]         wr;
    logic [15:0]         e8;
    react    = react_decode(st_r.ctrl.reaction);
    thr      = 16'h0000;
    hyst     = 17'sh0_0000;
    upper    = 17'sh0_0000;
    lower    = 17'sh0_0000;
    meas     = 17'sh0_0000;
    req      = 1'b0;
    crossed  = 1'b0;
    act      = A_NO;
    dsec     = 12'h000;
    commit   = 1'b0;
    cyc_fire = 1'b0;
    wr       = 32'h0000_0000;
    e8       = 16'h0000;
    st_nxt   = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.tx  = '0;

    // An external source falls back on the fixed value until one arrives.
    // Received values pass the same clamp, so a stray object cannot leave the legal band.
    if (st_r.ctrl.src != lvm_pkg::LVM_SRC_FIXED && st_r.ext_valid) begin
      thr = clamp_thr(st_r.ext_thr);
    end else begin
      thr = clamp_thr(st_r.cfg_thr);
    end
    hyst = hyst_tenths(st_r.ctrl.hyst);
    meas = 17'($signed(meas_value));
    if (react.ex_first) begin
      upper = 17'($signed(thr));
      lower = 17'($signed(thr) - hyst);
    end else begin
      upper = 17'($signed(thr) + hyst);
      lower = 17'($signed(thr));
    end

    // Hysteresis band: only the crossing away from the present side counts.
    if (!st_r.cond && meas > upper) begin
      crossed = 1'b1;
      st_nxt.cond = 1'b1;
      act = react.act_exc;
    end else if (st_r.cond && meas < lower) begin
      crossed = 1'b1;
      st_nxt.cond = 1'b0;
      act = react.act_und;
    end
    if (crossed) begin
      if (act == A_NO) begin
        st_nxt.silent = 1'b1;
      end else begin
        st_nxt.silent = 1'b0;
        st_nxt.target = (act == A_ON);
      end
    end

    // Delay timer: the object follows the target only once the delay has run out.
    // The divider runs free, so the first counted second may be short by up to one tick.
    if (st_r.target == st_r.out) begin
      st_nxt.dly_cnt = 12'h000;
    end else begin
      dsec = st_r.target ? delay_secs(st_r.ctrl.on_dly) : delay_secs(st_r.ctrl.off_dly);
      if (dsec == 12'h000) begin
        commit = 1'b1;
      end else if (tick_1s) begin
        if (12'(st_r.dly_cnt + 12'h001) >= dsec) begin
          commit = 1'b1;
        end else begin
          st_nxt.dly_cnt = 12'(st_r.dly_cnt + 12'h001);
        end
      end
    end
    if (commit) begin
      st_nxt.out = st_r.target;
      st_nxt.dly_cnt = 12'h000;
    end
    // A target that flips back before expiry starts the wait over.
    if (st_nxt.target != st_r.target) begin
      st_nxt.dly_cnt = 12'h000;
    end

    // Cyclic repeat counted in seconds; zero setting keeps the counter parked.
    // The counter is not restarted by a change, so the cyclic phase never drifts.
    if (st_r.cycle == 7'h00) begin
      st_nxt.cyc_cnt = 11'h000;
    end else if (tick_1s) begin
      if (11'(st_r.cyc_cnt + 11'h001) >= 11'(11'(st_r.cycle) * `LVM_CYCLE_UNIT_S)) begin
        st_nxt.cyc_cnt = 11'h000;
        cyc_fire = 1'b1;
      end else begin
        st_nxt.cyc_cnt = 11'(st_r.cyc_cnt + 11'h001);
      end
    end

    // One telegram per cycle; a change telegram carries the new value.
    // A cyclic telegram that meets a commit carries the committed level, so the
    // telegram never disagrees with the object it reports.
    if (commit && st_r.ctrl.soc) begin
      st_nxt.tx = '{valid: 1'b1, value: st_r.target};
    end else if (cyc_fire && !st_r.silent) begin
      st_nxt.tx = '{valid: 1'b1, value: st_nxt.out};
    end

    // Wishbone slave: one access per request, ack for one cycle.
    // A write lands at the taking edge; the set ack blocks a second take of the same strobe.
    // Any write to control, threshold or cycle counts as a download.
    req = wb_cyc_i && wb_stb_i && !st_r.ack;
    if (req) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (wb_we_i) begin
        case (wb_adr_i)
          `LVM_A_CTRL: begin
            wr = merge(32'(st_r.ctrl), wb_dat_i, wb_sel_i);
            st_nxt.ctrl = wr & `LVM_CTRL_WMASK;
            st_nxt.ext_valid = 1'b0;
          end
          `LVM_A_THRESH: begin
            wr = merge({16'h0000, st_r.cfg_thr}, wb_dat_i, wb_sel_i);
            st_nxt.cfg_thr = clamp_thr(wr[15:0]);
            st_nxt.ext_valid = 1'b0;
          end
          `LVM_A_CYCLE: begin
            wr = merge({25'h000_0000, st_r.cycle}, wb_dat_i, wb_sel_i);
            st_nxt.cycle = (wr[31:0] > 32'(`LVM_CYCLE_MAX)) ? `LVM_CYCLE_MAX : wr[6:0];
            st_nxt.ext_valid = 1'b0;
          end
          `LVM_A_EXT16: begin
            if (st_r.ctrl.src == lvm_pkg::LVM_SRC_EXT16) begin
              wr = merge({16'h0000, st_r.ext_thr}, wb_dat_i, wb_sel_i);
              st_nxt.ext_thr = wr[15:0];
              st_nxt.ext_valid = 1'b1;
            end
          end
          `LVM_A_EXT8: begin
            if (st_r.ctrl.src == lvm_pkg::LVM_SRC_EXT8 && wb_sel_i[0]) begin
              e8 = 16'($signed(wb_dat_i[7:0]) * $signed(16'h000A));
              st_nxt.ext_thr = e8;
              st_nxt.ext_valid = 1'b1;
            end
          end
          `LVM_A_TEACH: begin
            if (st_r.ctrl.src == lvm_pkg::LVM_SRC_TEACH && wb_sel_i[0] && wb_dat_i[0]) begin
              st_nxt.ext_thr = meas_value;
              st_nxt.ext_valid = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end else begin
        case (wb_adr_i)
          `LVM_A_CTRL:   st_nxt.rdata = 32'(st_r.ctrl);
          `LVM_A_THRESH: st_nxt.rdata = {16'h0000, st_r.cfg_thr};
          `LVM_A_CYCLE:  st_nxt.rdata = {25'h000_0000, st_r.cycle};
          `LVM_A_EXT16:  st_nxt.rdata = {16'h0000, st_r.ext_thr};
          `LVM_A_STATUS: begin
            st_nxt.rdata[`LVM_ST_OUT]    = st_r.out;
            st_nxt.rdata[`LVM_ST_TARGET] = st_r.target;
            st_nxt.rdata[`LVM_ST_COND]   = st_r.cond;
            st_nxt.rdata[`LVM_ST_PEND]   = (st_r.target != st_r.out);
            st_nxt.rdata[`LVM_ST_EXTV]   = st_r.ext_valid;
            st_nxt.rdata[`LVM_ST_SILENT] = st_r.silent;
            st_nxt.rdata[`LVM_ST_THR_LSB +: 16] = thr;
          end
          `LVM_A_MEAS:   st_nxt.rdata = {16'h0000, meas_value};
          default:       st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output is a field of the state register.
  // No output passes through logic, so the bus and the telegram see clean levels.
  assign wb_ack_o  = st_r.ack;
  assign wb_dat_o  = st_r.rdata;
  assign tx_valid  = st_r.tx.valid;
  assign tx_value  = st_r.tx.value;
  assign limit_out = st_r.out;

endmodule
`default_nettype wire

// file: verif/lvm_core_checker.sv
`timescale 1ns/10ps
`default_nettype none
module lvm_core_checker #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset_n,
  // Wishbone slave.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Sensor and telegram side.
  input wire logic [15:0] meas_value,
  input wire logic        tx_valid,
  input wire logic        tx_value,
  input wire logic        limit_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic soc_r;

  // Track send-on-change from CTRL writes; it takes effect at the taking edge, as the write does.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soc_r <= 1'b1;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]) begin
      soc_r <= wb_dat_i[6];
    end
  end

  // A request is a strobe that has not yet been answered.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_status;
    s_req ##0 (!wb_we_i && wb_adr_i == 8'h18);
  endsequence

  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  a_rdat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved without ack");
  a_unmapped_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i >= 8'h20) |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_meas_read: assert property (s_req ##0 (!wb_we_i && wb_adr_i == 8'h1C) |=> wb_dat_o[15:0] == $past(meas_value))
    else $error("measured value read wrong");
  a_status_out: assert property (s_rd_status |=> wb_dat_o[0] == $past(limit_out)) else $error("status out bit wrong");
  a_thr_range: assert property (s_rd_status |=> $signed(wb_dat_o[31:16]) >= -150 && $signed(wb_dat_o[31:16]) <= 500)
    else $error("active threshold out of range");
  a_tx_value: assert property (tx_valid |-> tx_value == limit_out)
    else $error("telegram value differs from object");
  a_change_sends: assert property (soc_r && $changed(limit_out) |-> tx_valid)
    else $error("no telegram on change");
endmodule

bind lvm_core lvm_core_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .meas_value(meas_value), .tx_valid(tx_valid), .tx_value(tx_value), .limit_out(limit_out)
);
`default_nettype wire

// file: verif/lvm_sink.sv
`timescale 1ns/10ps
`default_nettype none
module lvm_sink (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Telegram stream from the monitor.
  input  wire logic        tx_valid,
  input  wire logic        tx_value,
  // Receiver view.
  output logic [15:0]      rx_cnt,
  output logic             rx_last
);
  // A participant sees whole telegrams only, so it just counts them and keeps the last value.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_cnt  <= 16'h0000;
      rx_last <= 1'b0;
    end else if (tx_valid) begin
      rx_cnt  <= rx_cnt + 16'h0001;
      rx_last <= tx_value;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk, reset_n, cyc, stb, we, ack, txv, txd, lout, rx_last;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rd;
  logic [15:0] meas, rx_cnt;
  int          fail_count, num_checks, s;

  lvm_core #(.TICK_CYCLES(10)) DUT (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .meas_value(meas), .tx_valid(txv), .tx_value(txd), .limit_out(lout));
  lvm_sink u_sink (.clk(clk), .reset_n(reset_n), .tx_valid(txv), .tx_value(txd), .rx_cnt(rx_cnt), .rx_last(rx_last));

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic print_verdict();
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo(input string nm);
    fail_count++;
    $display("[ERR] %s expected event seen timeout", nm);
    print_verdict();
  endtask

  task automatic rst();
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask

  // Classic single cycle: the request stands until ack is sampled, then drops for a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= sl;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) tmo("wb ack");
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Checks the object level each cycle; any telegram seen meanwhile must carry the same level.
  task automatic hold(input logic e, input int n);
    s = 0;
    repeat (n) begin
      @(posedge clk);
      chk("held out", 32'(e), 32'(lout));
      if (txv === 1'b1) begin
        s++;
        chk("cyclic value", 32'(e), 32'(txd));
      end
    end
  endtask

  task automatic wait_out(input logic e, input int lim);
    int n;
    n = 0;
    while (lout !== e && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (lout !== e) tmo("limit out");
  endtask

  task automatic wait_tx(input int lim);
    s = 0;
    do begin
      @(posedge clk);
      s++;
    end while (txv !== 1'b1 && s < lim);
    if (txv !== 1'b1) tmo("telegram");
  endtask

  task automatic t_regs();
    rst();
    wb(0, 8'h00, 0, 4'hF);
    chk("ctrl reset", 32'h0000_0040, rd);
    wb(0, 8'h04, 0, 4'hF);
    chk("thresh reset", 32'h0000_00C8, {16'h0000, rd[15:0]});
    wb(0, 8'h08, 0, 4'hF);
    chk("cycle reset", 32'h0000_0000, rd);
    wb(0, 8'h24, 0, 4'hF);
    chk("unmapped", 32'h0000_0000, rd);
    wb(0, 8'h1C, 0, 4'hF);
    chk("meas", 32'(meas), {16'h0000, rd[15:0]});
    wb(1, 8'h00, 32'hFFFF_FFFF, 4'hF);
    wb(0, 8'h00, 0, 4'hF);
    chk("ctrl mask", 32'h000F_FF7F, rd);
    wb(1, 8'h04, 32'h0000_2710, 4'hF);
    wb(0, 8'h04, 0, 4'hF);
    chk("thresh high", 32'h0000_01F4, {16'h0000, rd[15:0]});
    wb(1, 8'h04, 32'h0000_FED4, 4'hF);
    wb(0, 8'h04, 0, 4'hF);
    chk("thresh low", 32'h0000_FF6A, {16'h0000, rd[15:0]});
  endtask

  // Every reaction code against one crossing walk with 1 K hysteresis, predicted by a small model.
  task automatic t_modes();
    int sq[7] = '{100, 250, 195, 205, 150, 205, 250};
    int ae[12] = '{1, 2, 2, 1, 1, 2, 0, 0, 0, 0, 2, 1};
    int au[12] = '{2, 1, 1, 2, 0, 0, 1, 2, 2, 1, 0, 0};
    int up, lo, a, ntx, n0;
    logic c, o;
    for (int r = 0; r < 12; r++) begin
      meas <= 16'h0064;
      rst();
      wb(1, 8'h00, 32'h0000_0140 | 32'(r), 4'hF);
      up = (r % 4 < 2) ? 200 : 210;
      lo = (r % 4 < 2) ? 190 : 200;
      c = 1'b0;
      o = 1'b0;
      ntx = 0;
      n0 = int'(rx_cnt);
      for (int i = 0; i < 7; i++) begin
        meas <= 16'(sq[i]);
        repeat (4) @(posedge clk);
        a = 0;
        if (!c && sq[i] > up) begin
          c = 1'b1;
          a = ae[r];
        end else if (c && sq[i] < lo) begin
          c = 1'b0;
          a = au[r];
        end
        if (a != 0 && o != (a == 1)) ntx++;
        if (a != 0) o = (a == 1);
        chk("mode out", 32'(o), 32'(lout));
      end
      chk("mode telegrams", 32'(n0 + ntx), 32'(rx_cnt));
    end
  endtask

  // On delay 15 s with a 10 s cycle, restarted once by a short dip, then off delay 15 s.
  task automatic t_delay();
    meas <= 16'h0064;
    rst();
    wb(1, 8'h00, 32'h0005_5040, 4'hF);
    wb(1, 8'h08, 32'h0000_0001, 4'hF);
    meas <= 16'h00FA;
    hold(1'b0, 70);
    meas <= 16'h0064;
    hold(1'b0, 10);
    meas <= 16'h00FA;
    hold(1'b0, 135);
    chk("cyclic during on delay", 32'h0000_0001, 32'(s > 0));
    wait_out(1'b1, 30);
    meas <= 16'h0064;
    hold(1'b1, 135);
    chk("cyclic during off delay", 32'h0000_0001, 32'(s > 0));
    wait_out(1'b0, 30);
  endtask

  // Cyclic period, no change telegram without send-on-change, clamp, zero cycle and silence.
  task automatic t_cyclic();
    int n0;
    meas <= 16'h0064;
    rst();
    wb(1, 8'h00, 32'h0000_0000, 4'hF);
    wb(1, 8'h08, 32'h0000_0002, 4'hF);
    wait_tx(250);
    wait_tx(250);
    chk("cycle period", 32'd200, 32'(s));
    meas <= 16'h00FA;
    @(posedge clk);
    n0 = int'(rx_cnt);
    repeat (3) @(posedge clk);
    hold(1'b1, 10);
    chk("no change telegram", 32'(n0), 32'(rx_cnt));
    wait_tx(250);
    chk("cyclic carries 1", 32'h0000_0001, 32'(txd));
    wb(1, 8'h08, 32'h0000_00C8, 4'hF);
    wb(0, 8'h08, 0, 4'hF);
    chk("cycle clamp", 32'h0000_0078, rd);
    wb(1, 8'h08, 32'h0000_0000, 4'hF);
    hold(1'b1, 400);
    chk("never sent", 32'h0000_0000, 32'(s));
    wb(1, 8'h00, 32'h0000_0004, 4'hF);
    wb(1, 8'h08, 32'h0000_0001, 4'hF);
    meas <= 16'h0064;
    repeat (4) @(posedge clk);
    hold(1'b1, 250);
    chk("silent cyclic", 32'h0000_0000, 32'(s));
  endtask

  task automatic thr(input logic [15:0] e);
    wb(0, 8'h18, 0, 4'hF);
    chk("active thresh", 32'(e), 32'(rd[31:16]));
  endtask

  task automatic t_ext();
    meas <= 16'h00FA;
    rst();
    wb(1, 8'h00, 32'h0000_0050, 4'hF);
    wb(1, 8'h04, 32'h0000_00C8, 4'hF);
    thr(16'h00C8);
    wb(1, 8'h0C, 32'h0000_012C, 4'h3);
    repeat (4) @(posedge clk);
    thr(16'h012C);
    chk("ext out", 32'h0000_0000, 32'(lout));
    wb(1, 8'h10, 32'h0000_0028, 4'h1);
    thr(16'h012C);
    wb(1, 8'h04, 32'h0000_00C8, 4'hF);
    thr(16'h00C8);
    wb(1, 8'h00, 32'h0000_0060, 4'hF);
    wb(1, 8'h10, 32'h0000_0028, 4'h1);
    thr(16'h0190);
    wb(1, 8'h00, 32'h0000_0070, 4'hF);
    meas <= 16'h007B;
    wb(1, 8'h14, 32'h0000_0001, 4'h1);
    thr(16'h007B);
    meas <= 16'h004D;
    wb(1, 8'h14, 32'h0000_0001, 4'h1);
    thr(16'h004D);
    wb(1, 8'h00, 32'h0000_0070, 4'hF);
    thr(16'h00C8);
  endtask

  // Main sequence.
  initial begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    meas = 16'h0064;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_modes();
    t_delay();
    t_cyclic();
    t_ext();
    print_verdict();
  end
endmodule
`default_nettype wire
